//--- ufb_pkg.sv
// constants and types for the synchronous fifo bus port
// ============================================================
package ufb_pkg;

	// ============================================================
	// bus geometry and buffering
	localparam int           DATA_W    = 32;
	localparam int           BE_W      = 4;
	localparam int           WORD_W    = DATA_W + BE_W;
	localparam int           BUF_DEPTH = 4;
	localparam int           PTR_W     = 2;
	localparam int           CNT_W     = 3;
	localparam logic [2:0]   CNT_ZERO  = 3'h0;
	localparam logic [2:0]   CNT_ONE   = 3'h1;
	localparam logic [2:0]   CNT_FULL  = 3'h4;
	localparam logic [1:0]   PTR_ONE   = 2'h1;
	localparam logic [3:0]   BE_ALL    = 4'hF;

	// ============================================================
	// pin synchroniser layout
	localparam int           SYNC_W    = 7;
	localparam logic [6:0]   SYNC_RST  = 7'h7F;
	localparam int           SY_WR     = 0;
	localparam int           SY_RD     = 1;
	localparam int           SY_OE     = 2;
	localparam int           SY_RSV    = 3;
	localparam int           SY_WAKE   = 4;
	localparam int           SY_MS0    = 5;
	localparam int           SY_MS1    = 6;

	// ============================================================
	// mode straps
	localparam logic [1:0]   STRAP_WAIT = 2'h2;
	localparam logic [1:0]   MS_SYNC    = 2'h0;
	localparam logic [1:0]   MS_CH1     = 2'h1;
	localparam logic [1:0]   MS_CH2     = 2'h2;
	localparam logic [1:0]   MS_CH4     = 2'h3;

	typedef enum logic [1:0] {
		UFB_MODE_SYNC,
		UFB_MODE_CH1,
		UFB_MODE_CH2,
		UFB_MODE_CH4
	} ufb_mode_e;

	// ============================================================
	// clock rates in kHz
	localparam int           CLK_KHZ     = 20000;
	localparam int           BUS_DIV     = 2;
	localparam int           BUS_KHZ     = CLK_KHZ / BUS_DIV;
	localparam int           BUS_KHZ_LO  = 66670;
	localparam int           BUS_KHZ_HI  = 100000;

endpackage

//--- ufb_bus_port.sv
// slave side of the synchronous parallel fifo bus
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps

module ufb_bus_port (
	input  wire logic                        clk,
	input  wire logic                        resetn,
	output logic                             fifo_clk,
	input  wire logic [ufb_pkg::DATA_W-1:0]  data_in,
	output logic      [ufb_pkg::DATA_W-1:0]  data_out,
	output logic                             data_oe_n,
	input  wire logic [ufb_pkg::BE_W-1:0]    be_in,
	output logic      [ufb_pkg::BE_W-1:0]    be_out,
	output logic                             be_oe_n,
	output logic                             rx_data_avail_n,
	output logic                             tx_space_avail_n,
	input  wire logic                        wr_n,
	input  wire logic                        rd_n,
	input  wire logic                        oe_n,
	input  wire logic                        reserved_wake_in_n,
	input  wire logic                        wakeup_in,
	output logic                             wakeup_out,
	output logic                             wakeup_oe_n,
	input  wire logic                        mode_select_0,
	input  wire logic                        mode_select_1,
	input  wire logic                        usb_rx_valid,
	input  wire logic [ufb_pkg::DATA_W-1:0]  usb_rx_data,
	output logic                             usb_rx_ready,
	output logic                             usb_tx_valid,
	output logic      [ufb_pkg::DATA_W-1:0]  usb_tx_data,
	output logic      [ufb_pkg::BE_W-1:0]    usb_tx_be,
	input  wire logic                        usb_tx_ready,
	input  wire logic                        usb_suspended,
	input  wire logic                        remote_wake_en,
	output logic                             remote_wakeup_req,
	output ufb_pkg::ufb_mode_e               bus_mode,
	output logic                             reserved_wake_low
);

	// ============================================================
	// declarations
	logic [ufb_pkg::SYNC_W-1:0]  pin_m;
	logic [ufb_pkg::SYNC_W-1:0]  pin_s;
	logic [ufb_pkg::WORD_W-1:0]  bus_m;
	logic [ufb_pkg::WORD_W-1:0]  bus_s;
	logic                        bus_tick;
	logic                        is_sync;
	logic [1:0]                  strap_cnt;
	logic                        strap_done;
	logic [1:0]                  strap_val;
	logic                        chan_cmd;
	logic                        chan_ack;
	logic                        next_chan_cmd;
	logic                        next_chan_ack;
	logic                        wake_prev;

	logic [ufb_pkg::DATA_W-1:0]  rx_mem [ufb_pkg::BUF_DEPTH];
	logic [ufb_pkg::PTR_W-1:0]   rx_wr_ptr;
	logic [ufb_pkg::PTR_W-1:0]   rx_rd_ptr;
	logic [ufb_pkg::CNT_W-1:0]   rx_cnt;
	logic [ufb_pkg::CNT_W-1:0]   next_rx_cnt;
	logic                        rx_push;
	logic                        rx_pop;

	logic [ufb_pkg::WORD_W-1:0]  tx_mem [ufb_pkg::BUF_DEPTH];
	logic [ufb_pkg::PTR_W-1:0]   tx_wr_ptr;
	logic [ufb_pkg::PTR_W-1:0]   tx_rd_ptr;
	logic [ufb_pkg::CNT_W-1:0]   tx_cnt;
	logic [ufb_pkg::CNT_W-1:0]   next_tx_cnt;
	logic                        tx_push;
	logic                        tx_pop;

	// ============================================================
	// fifo bus clock, half the core clock
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fifo_clk <= 1'b0;
		end else begin
			fifo_clk <= ~fifo_clk;
		end
	end

	// sampling point: the core edge at which fifo_clk rises
	assign bus_tick = ~fifo_clk;

	// ============================================================
	// pin synchronisers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pin_m <= ufb_pkg::SYNC_RST;
			pin_s <= ufb_pkg::SYNC_RST;
		end else begin
			pin_m <= {mode_select_1, mode_select_0, wakeup_in,
				reserved_wake_in_n, oe_n, rd_n, wr_n};
			pin_s <= pin_m;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bus_m <= '0;
			bus_s <= '0;
		end else begin
			bus_m <= {be_in, data_in};
			bus_s <= bus_m;
		end
	end

	// ============================================================
	// mode strap capture after reset release
	assign strap_val = {pin_s[ufb_pkg::SY_MS1], pin_s[ufb_pkg::SY_MS0]};

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			strap_cnt  <= '0;
			strap_done <= 1'b0;
			bus_mode   <= ufb_pkg::UFB_MODE_SYNC;
		end else if (!strap_done) begin
			if (strap_cnt == ufb_pkg::STRAP_WAIT) begin
				strap_done <= 1'b1;
				unique case (strap_val)
					ufb_pkg::MS_SYNC: bus_mode <= ufb_pkg::UFB_MODE_SYNC;
					ufb_pkg::MS_CH1:  bus_mode <= ufb_pkg::UFB_MODE_CH1;
					ufb_pkg::MS_CH2:  bus_mode <= ufb_pkg::UFB_MODE_CH2;
					ufb_pkg::MS_CH4:  bus_mode <= ufb_pkg::UFB_MODE_CH4;
				endcase
			end else begin
				strap_cnt <= strap_cnt + 2'h1;
			end
		end
	end

	assign is_sync = (bus_mode == ufb_pkg::UFB_MODE_SYNC);

	// ============================================================
	// receive buffer: usb side fills, bus master drains
	assign usb_rx_ready = (rx_cnt != ufb_pkg::CNT_FULL);
	assign rx_push      = usb_rx_valid & usb_rx_ready;
	assign rx_pop       = is_sync & bus_tick & ~pin_s[ufb_pkg::SY_RD]
		& (rx_cnt != ufb_pkg::CNT_ZERO);

	always_comb begin
		next_rx_cnt = rx_cnt;
		if (rx_push & ~rx_pop) begin
			next_rx_cnt = rx_cnt + ufb_pkg::CNT_ONE;
		end else if (rx_pop & ~rx_push) begin
			next_rx_cnt = rx_cnt - ufb_pkg::CNT_ONE;
		end
	end

	always_ff @(posedge clk) begin
		if (rx_push) begin
			rx_mem[rx_wr_ptr] <= usb_rx_data;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_wr_ptr <= '0;
			rx_rd_ptr <= '0;
			rx_cnt    <= ufb_pkg::CNT_ZERO;
		end else begin
			if (rx_push) begin
				rx_wr_ptr <= rx_wr_ptr + ufb_pkg::PTR_ONE;
			end
			if (rx_pop) begin
				rx_rd_ptr <= rx_rd_ptr + ufb_pkg::PTR_ONE;
			end
			rx_cnt <= next_rx_cnt;
		end
	end

	// ============================================================
	// transmit buffer: bus master fills, usb side drains
	assign tx_push = is_sync & bus_tick & ~pin_s[ufb_pkg::SY_WR]
		& (tx_cnt != ufb_pkg::CNT_FULL);
	assign tx_pop  = usb_tx_valid & usb_tx_ready;
	assign usb_tx_valid = (tx_cnt != ufb_pkg::CNT_ZERO);
	assign usb_tx_data  = tx_mem[tx_rd_ptr][ufb_pkg::DATA_W-1:0];
	assign usb_tx_be    = tx_mem[tx_rd_ptr][ufb_pkg::WORD_W-1:ufb_pkg::DATA_W];

	always_comb begin
		next_tx_cnt = tx_cnt;
		if (tx_push & ~tx_pop) begin
			next_tx_cnt = tx_cnt + ufb_pkg::CNT_ONE;
		end else if (tx_pop & ~tx_push) begin
			next_tx_cnt = tx_cnt - ufb_pkg::CNT_ONE;
		end
	end

	always_ff @(posedge clk) begin
		if (tx_push) begin
			tx_mem[tx_wr_ptr] <= bus_s;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_wr_ptr <= '0;
			tx_rd_ptr <= '0;
			tx_cnt    <= ufb_pkg::CNT_ZERO;
		end else begin
			if (tx_push) begin
				tx_wr_ptr <= tx_wr_ptr + ufb_pkg::PTR_ONE;
			end
			if (tx_pop) begin
				tx_rd_ptr <= tx_rd_ptr + ufb_pkg::PTR_ONE;
			end
			tx_cnt <= next_tx_cnt;
		end
	end

	// ============================================================
	// channelized request and acknowledge
	always_comb begin
		next_chan_cmd = chan_cmd;
		next_chan_ack = chan_ack;
		if (is_sync) begin
			next_chan_cmd = 1'b0;
			next_chan_ack = 1'b0;
		end else if (bus_tick) begin
			next_chan_cmd = ~pin_s[ufb_pkg::SY_WR];
			next_chan_ack = ~pin_s[ufb_pkg::SY_WR] & chan_cmd;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			chan_cmd <= 1'b0;
			chan_ack <= 1'b0;
		end else begin
			chan_cmd <= next_chan_cmd;
			chan_ack <= next_chan_ack;
		end
	end

	// ============================================================
	// status flags
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_data_avail_n  <= 1'b1;
			tx_space_avail_n <= 1'b1;
		end else if (is_sync) begin
			rx_data_avail_n  <= (next_rx_cnt == ufb_pkg::CNT_ZERO);
			tx_space_avail_n <= (next_tx_cnt == ufb_pkg::CNT_FULL);
		end else begin
			rx_data_avail_n  <= ~next_chan_ack;
			tx_space_avail_n <= ~pin_s[ufb_pkg::SY_WR];
		end
	end

	// ============================================================
	// read data drive
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			data_out  <= '0;
			be_out    <= '0;
			data_oe_n <= 1'b1;
			be_oe_n   <= 1'b1;
		end else begin
			data_out  <= rx_mem[rx_rd_ptr];
			be_out    <= ufb_pkg::BE_ALL;
			data_oe_n <= ~(is_sync & ~pin_s[ufb_pkg::SY_OE]);
			be_oe_n   <= ~(is_sync & ~pin_s[ufb_pkg::SY_OE]);
		end
	end

	// ============================================================
	// suspend indication and remote wakeup
	assign wakeup_out = 1'b0;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wakeup_oe_n       <= 1'b1;
			wake_prev         <= 1'b1;
			remote_wakeup_req <= 1'b0;
			reserved_wake_low <= 1'b0;
		end else begin
			wakeup_oe_n       <= usb_suspended;
			wake_prev         <= pin_s[ufb_pkg::SY_WAKE];
			remote_wakeup_req <= usb_suspended & remote_wake_en & wake_prev
				& ~pin_s[ufb_pkg::SY_WAKE] & wakeup_oe_n;
			reserved_wake_low <= ~pin_s[ufb_pkg::SY_RSV];
		end
	end

	// ============================================================
	// checks
	AST_RX_FLAG_LOW_HAS_DATA: assert property (@(posedge clk) disable iff (!resetn)
		is_sync && !rx_data_avail_n && !rx_pop |=> rx_cnt != ufb_pkg::CNT_ZERO)
		else $error("rx flag low with empty receive buffer");

	AST_RX_POP_NEEDS_DATA: assert property (@(posedge clk) disable iff (!resetn)
		rx_pop |-> !rx_data_avail_n && !pin_s[ufb_pkg::SY_RD] && !fifo_clk)
		else $error("read taken from empty buffer");

	AST_TX_PUSH_GATED: assert property (@(posedge clk) disable iff (!resetn)
		tx_push |-> !pin_s[ufb_pkg::SY_WR] && !fifo_clk && !tx_space_avail_n)
		else $error("write accepted without strobe or space");

	AST_TX_COUNT_STEP: assert property (@(posedge clk) disable iff (!resetn)
		tx_push && !tx_pop |=> tx_cnt == $past(tx_cnt) + ufb_pkg::CNT_ONE)
		else $error("write lost or doubled");

	AST_DATA_DRIVE_OE: assert property (@(posedge clk) disable iff (!resetn)
		!data_oe_n |-> $past(!pin_s[ufb_pkg::SY_OE]) && $past(is_sync))
		else $error("data bus driven without output enable");

	AST_CHAN_ACK_AFTER_REQ: assert property (@(posedge clk) disable iff (!resetn)
		!is_sync && $fell(rx_data_avail_n) |-> $past(chan_cmd) && $past(!pin_s[ufb_pkg::SY_WR]))
		else $error("transfer acknowledged without request");

	AST_WAKE_DRIVE_ACTIVE: assert property (@(posedge clk) disable iff (!resetn)
		!usb_suspended ##1 !usb_suspended |-> !wakeup_oe_n && !wakeup_out)
		else $error("wakeup pin not driven low while usb active");

	AST_REMOTE_WAKE_SUSPEND: assert property (@(posedge clk) disable iff (!resetn)
		remote_wakeup_req |-> $past(usb_suspended) && $past(remote_wake_en) && wakeup_oe_n)
		else $error("remote wakeup outside suspend");

	AST_FIFO_CLK_TOGGLE: assert property (@(posedge clk) disable iff (!resetn)
		fifo_clk |=> !fifo_clk ##1 fifo_clk)
		else $error("fifo clock not toggling");

	AST_MODE_FROZEN: assert property (@(posedge clk) disable iff (!resetn)
		strap_done |=> $stable(bus_mode) && strap_done)
		else $error("bus mode changed after capture");

	AST_RX_COUNT_STEP: assert property (@(posedge clk) disable iff (!resetn)
		rx_pop && !rx_push |=> rx_cnt == $past(rx_cnt) - ufb_pkg::CNT_ONE)
		else $error("read lost or doubled");

	AST_RX_FLAG_MATCH: assert property (@(posedge clk) disable iff (!resetn)
		is_sync |=> rx_data_avail_n == (rx_cnt == ufb_pkg::CNT_ZERO))
		else $error("rx flag disagrees with receive buffer");

	AST_TX_FLAG_MATCH: assert property (@(posedge clk) disable iff (!resetn)
		is_sync |=> tx_space_avail_n == (tx_cnt == ufb_pkg::CNT_FULL))
		else $error("tx flag disagrees with transmit buffer");

	AST_CHAN_NO_DATA: assert property (@(posedge clk) disable iff (!resetn)
		!is_sync |=> $stable(tx_wr_ptr) && $stable(rx_rd_ptr))
		else $error("data moved in channelized mode");

	AST_CHAN_OE_OFF: assert property (@(posedge clk) disable iff (!resetn)
		!is_sync |=> data_oe_n && be_oe_n)
		else $error("data bus driven in channelized mode");

endmodule

//--- ufb_fifo_master.sv
// behavioural fifo bus master facing the bridge port
`timescale 1ns/1ps

module ufb_fifo_master (
	input  wire logic                        fifo_clk,
	input  wire logic                        rx_data_avail_n,
	input  wire logic                        tx_space_avail_n,
	input  wire logic [ufb_pkg::DATA_W-1:0]  data_out,
	input  wire logic                        rd_en,
	input  wire logic                        rude,
	input  wire logic                        hold_req,
	output logic                             wr_n,
	output logic                             rd_n,
	output logic                             oe_n,
	output logic      [ufb_pkg::DATA_W-1:0]  data_in,
	output logic      [ufb_pkg::BE_W-1:0]    be_in,
	output logic                             reserved_wake_in_n
);
	logic [ufb_pkg::WORD_W-1:0]  wr_q[$];
	logic [ufb_pkg::DATA_W-1:0]  rd_q[$];

	assign reserved_wake_in_n = 1'b1;

	initial begin
		wr_n = 1'b1;
		rd_n = 1'b1;
		oe_n = 1'b1;
		data_in = '0;
		be_in = '0;
	end

	// ============================================================
	// one strobe per bus period, then one idle period, except that hold_req holds wr_n low; rude ignores flags
	always @(posedge fifo_clk) begin
		// act just after the edge so flags launched at it are settled
		#1;
		oe_n <= !rd_en;
		rd_n <= 1'b1;
		wr_n <= !hold_req;
		data_in <= ~data_in;
		be_in <= ~be_in;
		if (!rd_n)
			rd_q.push_back(data_out);
		else if (wr_n && rd_en && (!rx_data_avail_n || rude))
			rd_n <= 1'b0;
		else if (wr_n && wr_q.size() > 0 && (!tx_space_avail_n || rude)) begin
			wr_n <= 1'b0;
			{data_in, be_in} <= wr_q.pop_front();
		end
	end
endmodule

//--- tb_ufb_bus_port.sv
// self-checking testbench for the fifo bus port
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb_ufb_bus_port;
	localparam int DW = ufb_pkg::DATA_W;
	logic clk, resetn, fifo_clk, data_oe_n, be_oe_n, rx_data_avail_n, tx_space_avail_n;
	logic wr_n, rd_n, oe_n, reserved_wake_in_n, wakeup_out, wakeup_oe_n, app_low;
	logic mode_select_0, mode_select_1, usb_rx_valid, usb_rx_ready, usb_tx_valid;
	logic usb_tx_ready, usb_suspended, remote_wake_en, remote_wakeup_req;
	logic reserved_wake_low, rd_en, rude, hold_req, tx_go;
	logic [DW-1:0]                data_in, data_out, usb_rx_data, usb_tx_data;
	logic [ufb_pkg::BE_W-1:0]     be_in, be_out, usb_tx_be;
	logic [ufb_pkg::WORD_W-1:0]   w, w_exp;
	logic [ufb_pkg::WORD_W-1:0]   tx_exp[$];
	logic [DW-1:0]                rx_exp[$];
	ufb_pkg::ufb_mode_e           bus_mode;
	wire                          wakeup_in;
	int                           failures, checks_done, n, k, seed;

	// pull-up on the wake pin when nobody drives it
	assign wakeup_in = (wakeup_oe_n ? 1'b1 : wakeup_out) & !app_low;
	always #25 clk = !clk;

	ufb_bus_port DUT (.clk(clk), .resetn(resetn), .fifo_clk(fifo_clk), .data_in(data_in),
		.data_out(data_out), .data_oe_n(data_oe_n), .be_in(be_in), .be_out(be_out),
		.be_oe_n(be_oe_n), .rx_data_avail_n(rx_data_avail_n), .wr_n(wr_n), .rd_n(rd_n),
		.tx_space_avail_n(tx_space_avail_n), .oe_n(oe_n), .wakeup_in(wakeup_in),
		.reserved_wake_in_n(reserved_wake_in_n), .wakeup_out(wakeup_out),
		.wakeup_oe_n(wakeup_oe_n), .mode_select_0(mode_select_0), .mode_select_1(mode_select_1),
		.usb_rx_valid(usb_rx_valid), .usb_rx_data(usb_rx_data), .usb_rx_ready(usb_rx_ready),
		.usb_tx_valid(usb_tx_valid), .usb_tx_data(usb_tx_data), .usb_tx_be(usb_tx_be),
		.usb_tx_ready(usb_tx_ready), .usb_suspended(usb_suspended), .bus_mode(bus_mode),
		.remote_wake_en(remote_wake_en), .remote_wakeup_req(remote_wakeup_req),
		.reserved_wake_low(reserved_wake_low));

	ufb_fifo_master u_master (.fifo_clk(fifo_clk), .rx_data_avail_n(rx_data_avail_n),
		.tx_space_avail_n(tx_space_avail_n), .data_out(data_out), .rd_en(rd_en), .rude(rude),
		.hold_req(hold_req), .wr_n(wr_n), .rd_n(rd_n), .oe_n(oe_n), .data_in(data_in),
		.be_in(be_in), .reserved_wake_in_n(reserved_wake_in_n));

	// ============================================================
	// usb side consumer with random stalls
	always @(posedge clk) begin
		if (resetn && usb_tx_valid && usb_tx_ready) begin
			w_exp = tx_exp.pop_front();
			`CHK({usb_tx_data, usb_tx_be}, w_exp)
		end
		usb_tx_ready <= tx_go && ($urandom % 3 != 0);
	end

	task automatic finish_test();
		if (failures == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic give_up(input logic late);
		`CHK(late, 1'b0)
		if (late)
			finish_test();
	endtask

	task automatic do_reset(input logic [1:0] m);
		@(posedge clk);
		{mode_select_1, mode_select_0} <= m;
		resetn <= 1'b0;
		@(posedge clk);
		#1;
		`CHK({fifo_clk, rx_data_avail_n, tx_space_avail_n, data_oe_n, remote_wakeup_req}, 5'h0E)
		@(posedge clk);
		resetn <= 1'b1;
		repeat (6) @(posedge clk);
		#1;
		`CHK(bus_mode, ufb_pkg::ufb_mode_e'(m))
		@(posedge clk);
	endtask

	task automatic push_rx(input logic [DW-1:0] d);
		usb_rx_valid <= 1'b1;
		usb_rx_data <= d;
		n = 0;
		#1;
		while (!usb_rx_ready && n < 300) begin
			@(posedge clk);
			#1;
			n++;
		end
		give_up(!usb_rx_ready);
		@(posedge clk);
	endtask

	// ============================================================
	// main sequence
	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		{mode_select_1, mode_select_0} = 2'h0;
		{usb_rx_valid, usb_tx_ready, usb_suspended, remote_wake_en} = 4'h0;
		{app_low, rd_en, rude, hold_req, tx_go} = 5'h00;
		usb_rx_data = '0;
		failures = 0;
		checks_done = 0;
		seed = $urandom(32'h7BAC);
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		for (k = 3; k >= 0; k--)
			do_reset(k[1:0]);
		#1;
		for (k = 0; k < 4; k++) begin
			n = fifo_clk;
			@(posedge clk);
			#1;
			`CHK(fifo_clk, !n[0])
		end
		@(posedge clk);
		// receive path: fill, overflow refusal, then drain while refilling
		for (k = 0; k < 16; k++)
			rx_exp.push_back($urandom);
		for (k = 0; k < 4; k++)
			push_rx(rx_exp[k]);
		usb_rx_valid <= 1'b0;
		#1;
		`CHK({usb_rx_ready, rx_data_avail_n, data_oe_n}, 3'h1)
		@(posedge clk);
		rd_en <= 1'b1;
		for (k = 4; k < 16; k++)
			push_rx(rx_exp[k]);
		usb_rx_valid <= 1'b0;
		n = 0;
		while (u_master.rd_q.size() < 16 && n < 600) begin
			@(posedge clk);
			n++;
		end
		give_up(u_master.rd_q.size() < 16);
		repeat (4) @(posedge clk);
		#1;
		`CHK({data_oe_n, be_oe_n, be_out, reserved_wake_low}, 7'h1E)
		foreach (rx_exp[i]) `CHK(u_master.rd_q[i], rx_exp[i])
		`CHK(rx_data_avail_n, 1'b1)
		// reads against an empty buffer are ignored
		@(posedge clk);
		rude <= 1'b1;
		repeat (20) @(posedge clk);
		rude <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		`CHK(rx_data_avail_n, 1'b1)
		u_master.rd_q.delete();
		@(posedge clk);
		k = $urandom;
		push_rx(k);
		usb_rx_valid <= 1'b0;
		repeat (30) @(posedge clk);
		`CHK(u_master.rd_q.size(), 1)
		`CHK(u_master.rd_q[0], k[DW-1:0])
		// transmit path: writes into a full buffer are dropped
		rd_en <= 1'b0;
		rude <= 1'b1;
		for (k = 0; k < 6; k++) begin
			w = {$urandom, 4'($urandom)};
			u_master.wr_q.push_back(w);
			if (k < 4)
				tx_exp.push_back(w);
		end
		repeat (40) @(posedge clk);
		#1;
		`CHK({tx_space_avail_n, usb_tx_valid, u_master.wr_q.size() == 0}, 3'h7)
		@(posedge clk);
		rude <= 1'b0;
		tx_go <= 1'b1;
		for (k = 0; k < 20; k++) begin
			w = {$urandom, 4'($urandom)};
			u_master.wr_q.push_back(w);
			tx_exp.push_back(w);
		end
		n = 0;
		while ((tx_exp.size() > 0 || u_master.wr_q.size() > 0) && n < 1000) begin
			@(posedge clk);
			n++;
		end
		give_up(tx_exp.size() > 0);
		#1;
		`CHK(tx_space_avail_n, 1'b0)
		// channelized request and acknowledge, reset with data buffered
		@(posedge clk);
		push_rx($urandom);
		usb_rx_valid <= 1'b0;
		do_reset(2'h1);
		hold_req <= 1'b1;
		n = 0;
		while (rx_data_avail_n && n < 40) begin
			@(posedge clk);
			n++;
		end
		give_up(rx_data_avail_n);
		`CHK(usb_tx_valid, 1'b0)
		hold_req <= 1'b0;
		repeat (8) @(posedge clk);
		#1;
		`CHK(rx_data_avail_n, 1'b1)
		do_reset(2'h0);
		// wake pin and remote wakeup request
		#1;
		`CHK({wakeup_in, wakeup_oe_n}, 2'h0)
		@(posedge clk);
		usb_suspended <= 1'b1;
		for (k = 0; k < 2; k++) begin
			@(posedge clk);
			remote_wake_en <= k[0];
			app_low <= 1'b1;
			n = 0;
			repeat (8) begin
				@(posedge clk);
				#1;
				n += (remote_wakeup_req === 1'b1);
			end
			`CHK(n, k)
			`CHK(wakeup_oe_n, 1'b1)
			@(posedge clk);
			app_low <= 1'b0;
			repeat (4) @(posedge clk);
		end
		finish_test();
	end
endmodule
